// >>> panel_regs_pkg.sv
// Constants for the board strap and flat-panel control register bank.
// ---------------------------------------------------------------------------
// Operation
// - The strap pins are caught in a read-only register when reset is released.
// - A strap pin left open reads as one and the board pulls it low for a zero.
// - Strap bit 7 gives the host bus type and strap bit 4 the boot ROM size.
// - Strap bit 6 low means the engine clock synthesizer is bypassed.
// - Strap bit 5 low means the display, pixel and memory clocks are bypassed.
// - Panel status gives panel on in bit 0, sequencing busy in bit 1, zero above.
// - Compensation bit 7 turns on vertical expansion and resets to zero.
// - Compensation bit 5 turns on horizontal expansion and resets to zero.
// - Compensation bit 1 halves text and cursor blink rates and resets to zero.
// - Compensation bit 0 turns on text line insertion and resets to zero.
// - The scan FIFO register holds a two-bit threshold in bits 1:0, reset zero.
// ---------------------------------------------------------------------------
package panel_regs_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRAP_W = 8;
  localparam int THR_W = 2;
  localparam logic [ADDR_W-1:0] OFF_STRAP = 12'h4C0;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h500;
  localparam logic [ADDR_W-1:0] OFF_COMP = 12'h504;
  localparam logic [ADDR_W-1:0] OFF_THR = 12'h505;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int STRAP_BUS_BIT = 7;
  localparam int STRAP_SCLK_BIT = 6;
  localparam int STRAP_PIXEL_DOT_CLOCK_BIT = 5;
  localparam int STRAP_ROM_BIT = 4;
  localparam int STAT_ON_BIT = 0;
  localparam int STAT_SEQ_BIT = 1;
  localparam int COMP_VEXP_BIT = 7;
  localparam int COMP_HEXP_BIT = 5;
  localparam int COMP_BLINK_BIT = 1;
  localparam int COMP_LINS_BIT = 0;

  // ---------------------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------------------
  localparam logic [STRAP_W-1:0] STRAP_RST = 8'hFF;
  localparam logic [7:0] COMP_MASK = 8'hA3;
  localparam logic [7:0] COMP_RST = 8'h00;
  localparam logic [THR_W-1:0] THR_RST = 2'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

endpackage : panel_regs_pkg

// >>> reset_release_sync.sv
// Two-stage release synchroniser for the asynchronous chip reset.
`timescale 1ns/100ps
module reset_release_sync (
  // Clock and raw reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Synchronised reset
  output logic rst_sync_n
);
  logic meta_q;

  // The first stage feeds only the second, so release never races the logic.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      rst_sync_n <= meta_q;
    end
  end
endmodule : reset_release_sync

// >>> strap_latch.sv
// Catches the board strap pins once after reset release and holds them.
`timescale 1ns/100ps
module strap_latch
  import panel_regs_pkg::*;
#(
  parameter int W = STRAP_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_sync_n,
  // Strap pins
  input wire logic [W-1:0] strap_pins,
  // Caught value
  output logic [W-1:0] strap_q,
  output logic done_q
);
  typedef enum logic {ST_CAPTURE, ST_HOLD} latch_state_t;
  latch_state_t state_q;

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= ST_CAPTURE;
    end else begin
      unique case (state_q)
        ST_CAPTURE: state_q <= ST_HOLD;
        ST_HOLD: state_q <= ST_HOLD;
      endcase
    end
  end

  // Reset loads the open-pin value; pins are read only on the release edge.
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      strap_q <= W'(STRAP_RST);
    end else if (state_q == ST_CAPTURE) begin
      strap_q <= strap_pins;
    end
  end

  assign done_q = (state_q == ST_HOLD);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n);

  property p_strap_hold;
    done_q |=> $stable(strap_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap moved after capture");

  property p_strap_catch;
    !done_q ##1 done_q |-> strap_q == $past(strap_pins);
  endproperty
  a_strap_catch: assert property (p_strap_catch) else $error("strap not caught at release");
endmodule : strap_latch

// >>> strap_and_panel_ctrl_regs.sv
// Register bank for board straps, panel status and panel image controls.
`timescale 1ns/100ps
module strap_and_panel_ctrl_regs
  import panel_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Board strap pins
  input wire logic [STRAP_W-1:0] strap_pins,
  // Panel state from the sequencer
  input wire logic panel_on,
  input wire logic panel_seq_busy,
  // Strap-decoded modes
  output logic strap_valid,
  output logic host_bus_agp,
  output logic engine_clk_bypass,
  output logic disp_clk_bypass,
  output logic rom_size_64k,
  output logic [3:0] strap_sw_field,
  // Panel image controls
  output logic vert_expand_en,
  output logic horiz_expand_en,
  output logic blink_half_en,
  output logic text_line_insert_en,
  output logic [THR_W-1:0] dual_scan_panel_threshold
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] off
  );
    hit = (a == off);
  endfunction : hit

  function automatic logic [DATA_W-1:0] zext8(input logic [7:0] v);
    zext8 = {24'h00_0000, v};
  endfunction : zext8

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic rst_sync_n;

  reset_release_sync u_rst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .rst_sync_n(rst_sync_n)
  );

  // ---------------------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------------------
  logic [STRAP_W-1:0] strap_q;
  logic strap_done;

  strap_latch #(
    .W(STRAP_W)
  ) u_strap (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_n),
    .strap_pins(strap_pins),
    .strap_q(strap_q),
    .done_q(strap_done)
  );

  // Writes are never decoded for the strap offset, so it cannot be altered.
  assign strap_valid = strap_done;
  assign host_bus_agp = strap_q[STRAP_BUS_BIT];
  assign rom_size_64k = strap_q[STRAP_ROM_BIT];
  assign engine_clk_bypass = ~strap_q[STRAP_SCLK_BIT];
  assign disp_clk_bypass = ~strap_q[STRAP_PIXEL_DOT_CLOCK_BIT];
  assign strap_sw_field = strap_q[3:0];

  // ---------------------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------------------
  logic wr_comp;
  logic wr_thr;

  assign wr_comp = reg_wr && hit(reg_addr, OFF_COMP);
  assign wr_thr = reg_wr && hit(reg_addr, OFF_THR);

  // ---------------------------------------------------------------------------
  // Image compensation
  // ---------------------------------------------------------------------------
  logic [7:0] comp_q;

  // Reserved bits are masked off so they always read back as zero.
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      comp_q <= COMP_RST;
    end else if (wr_comp) begin
      comp_q <= reg_wdata[7:0] & COMP_MASK;
    end
  end

  assign vert_expand_en = comp_q[COMP_VEXP_BIT];
  assign horiz_expand_en = comp_q[COMP_HEXP_BIT];
  assign blink_half_en = comp_q[COMP_BLINK_BIT];
  assign text_line_insert_en = comp_q[COMP_LINS_BIT];

  // ---------------------------------------------------------------------------
  // Scan FIFO threshold
  // ---------------------------------------------------------------------------
  logic [THR_W-1:0] thr_q;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      thr_q <= THR_RST;
    end else if (wr_thr) begin
      thr_q <= reg_wdata[THR_W-1:0];
    end
  end

  assign dual_scan_panel_threshold = thr_q;

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] rd_d;

  always_comb begin
    rd_d = DATA_ZERO;
    if (hit(reg_addr, OFF_STRAP)) begin
      rd_d = zext8(strap_q);
    end else if (hit(reg_addr, OFF_STATUS)) begin
      rd_d[STAT_ON_BIT] = panel_on;
      rd_d[STAT_SEQ_BIT] = panel_seq_busy;
    end else if (hit(reg_addr, OFF_COMP)) begin
      rd_d = zext8(comp_q);
    end else if (hit(reg_addr, OFF_THR)) begin
      rd_d[THR_W-1:0] = thr_q;
    end
  end

  // Data stand only in the cycle after the strobe; otherwise the port is zero.
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= DATA_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end else begin
      reg_rdata <= DATA_ZERO;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n);

  sequence s_rd(logic [ADDR_W-1:0] off);
    reg_rd && (reg_addr == off);
  endsequence

  sequence s_wr(logic [ADDR_W-1:0] off);
    reg_wr && (reg_addr == off);
  endsequence

  property p_strap_ro;
    s_wr(OFF_STRAP) |=> $stable(strap_q);
  endproperty
  a_strap_ro: assert property (p_strap_ro) else $error("strap register changed on write");

  property p_strap_read;
    s_rd(OFF_STRAP) |=> reg_rdata == zext8($past(strap_q));
  endproperty
  a_strap_read: assert property (p_strap_read) else $error("strap read data wrong");

  property p_bus_rom;
    s_rd(OFF_STRAP) |=> reg_rdata[STRAP_BUS_BIT] == $past(host_bus_agp)
      && reg_rdata[STRAP_ROM_BIT] == $past(rom_size_64k);
  endproperty
  a_bus_rom: assert property (p_bus_rom) else $error("bus or rom decode wrong");

  property p_clk_bypass;
    s_rd(OFF_STRAP) |=> reg_rdata[STRAP_SCLK_BIT] != $past(engine_clk_bypass);
  endproperty
  a_clk_bypass: assert property (p_clk_bypass) else $error("bypass polarity wrong");

  property p_disp_bypass;
    s_rd(OFF_STRAP) |=> reg_rdata[STRAP_PIXEL_DOT_CLOCK_BIT] != $past(disp_clk_bypass);
  endproperty
  a_disp_bypass: assert property (p_disp_bypass) else $error("display bypass wrong");

  property p_status;
    s_rd(OFF_STATUS) |=> reg_rdata[DATA_W-1:2] == '0
      && reg_rdata[STAT_ON_BIT] == $past(panel_on)
      && reg_rdata[STAT_SEQ_BIT] == $past(panel_seq_busy);
  endproperty
  a_status: assert property (p_status) else $error("panel status read wrong");

  property p_comp_wr;
    s_wr(OFF_COMP) ##1 s_rd(OFF_COMP) |=>
      reg_rdata == zext8($past(reg_wdata[7:0], 2) & COMP_MASK);
  endproperty
  a_comp_wr: assert property (p_comp_wr) else $error("compensation write lost");

  property p_comp_out;
    s_wr(OFF_COMP) |=> vert_expand_en == $past(reg_wdata[COMP_VEXP_BIT])
      && horiz_expand_en == $past(reg_wdata[COMP_HEXP_BIT])
      && blink_half_en == $past(reg_wdata[COMP_BLINK_BIT])
      && text_line_insert_en == $past(reg_wdata[COMP_LINS_BIT]);
  endproperty
  a_comp_out: assert property (p_comp_out) else $error("compensation outputs wrong");

  property p_comp_hold;
    !wr_comp |=> $stable(comp_q);
  endproperty
  a_comp_hold: assert property (p_comp_hold) else $error("compensation moved without write");

  property p_comp_reset;
    $rose(rst_sync_n) |-> comp_q == COMP_RST;
  endproperty
  a_comp_reset: assert property (p_comp_reset)
    else $error("compensation not zero after reset");

  property p_thr;
    s_wr(OFF_THR) ##1 s_rd(OFF_THR) |=>
      reg_rdata == {30'h0000_0000, $past(reg_wdata[THR_W-1:0], 2)};
  endproperty
  a_thr: assert property (p_thr) else $error("threshold readback wrong");

  property p_idle_zero;
    !reg_rd |=> reg_rdata == DATA_ZERO;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data without strobe");

  // ---------------------------------------------------------------------------
  // Strap release checks
  // ---------------------------------------------------------------------------
  // The open-pin value must still stand on the first edge out of reset, so a
  // read that races the capture shows ones rather than stale board levels.
  sequence s_release;
    $rose(rst_sync_n);
  endsequence

  property p_strap_open;
    s_release |-> strap_q == STRAP_RST && !strap_valid;
  endproperty
  a_strap_open: assert property (p_strap_open)
    else $error("strap not open value at release");

  property p_valid_rise;
    s_release |=> strap_valid;
  endproperty
  a_valid_rise: assert property (p_valid_rise)
    else $error("strap valid late after release");

  property p_valid_hold;
    strap_valid |=> strap_valid;
  endproperty
  a_valid_hold: assert property (p_valid_hold)
    else $error("strap valid dropped");

  property p_strap_wr_clean;
    s_wr(OFF_STRAP) |=> $stable(comp_q) && $stable(thr_q);
  endproperty
  a_strap_wr_clean: assert property (p_strap_wr_clean)
    else $error("strap write reached a neighbour");

  // ---------------------------------------------------------------------------
  // Compensation and threshold checks
  // ---------------------------------------------------------------------------
  // Reserved compensation bits must never hold a one, or a later read-modify-write
  // from software would carry it back into the register.
  property p_comp_reserved;
    (comp_q & ~COMP_MASK) == '0;
  endproperty
  a_comp_reserved: assert property (p_comp_reserved)
    else $error("reserved compensation bit set");

  property p_comp_read;
    s_rd(OFF_COMP) |=> reg_rdata == zext8($past(comp_q));
  endproperty
  a_comp_read: assert property (p_comp_read)
    else $error("compensation read data wrong");

  // The threshold steers the scan FIFO directly, so it only ever moves on a write
  // to its own offset.
  property p_thr_hold;
    !wr_thr |=> $stable(thr_q);
  endproperty
  a_thr_hold: assert property (p_thr_hold)
    else $error("threshold moved without write");

  property p_thr_out;
    s_wr(OFF_THR) |=> dual_scan_panel_threshold == $past(reg_wdata[THR_W-1:0]);
  endproperty
  a_thr_out: assert property (p_thr_out)
    else $error("threshold output wrong");

  property p_thr_reset;
    s_release |-> thr_q == THR_RST;
  endproperty
  a_thr_reset: assert property (p_thr_reset)
    else $error("threshold not zero after reset");

  property p_thr_read;
    s_rd(OFF_THR) |=> reg_rdata == {30'h0000_0000, $past(thr_q)};
  endproperty
  a_thr_read: assert property (p_thr_read)
    else $error("threshold read data wrong");

  property p_thr_reserved;
    s_rd(OFF_THR) |=> reg_rdata[DATA_W-1:THR_W] == '0;
  endproperty
  a_thr_reserved: assert property (p_thr_reserved)
    else $error("threshold reserved bits set");

  // ---------------------------------------------------------------------------
  // Read port checks
  // ---------------------------------------------------------------------------
  // Any address outside the four registers reads as zero, so probing code sees
  // no ghost copies of the strap or status words.
  sequence s_rd_unmapped;
    reg_rd && !hit(reg_addr, OFF_STRAP) && !hit(reg_addr, OFF_STATUS)
      && !hit(reg_addr, OFF_COMP) && !hit(reg_addr, OFF_THR);
  endsequence

  property p_unmapped;
    s_rd_unmapped |=> reg_rdata == DATA_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_status_wr;
    s_wr(OFF_STATUS) |=> $stable(comp_q) && $stable(thr_q) && $stable(strap_q);
  endproperty
  a_status_wr: assert property (p_status_wr)
    else $error("status write reached a register");

  property p_wr_no_rdata;
    reg_wr |=> reg_rdata == DATA_ZERO;
  endproperty
  a_wr_no_rdata: assert property (p_wr_no_rdata)
    else $error("read data after a write");

endmodule : strap_and_panel_ctrl_regs

// >>> strap_and_panel_ctrl_regs_bench.sv
// Self-checking bench for the strap and panel register bank.
`timescale 1ns/100ps
module strap_and_panel_ctrl_regs_bench;
  import panel_regs_pkg::*;

  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic clk_sys, rst_n, reg_wr, reg_rd, panel_on, panel_seq_busy;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
  logic [STRAP_W-1:0] strap_pins, s;
  logic strap_valid, host_bus_agp, engine_clk_bypass, disp_clk_bypass, rom_size_64k;
  logic [3:0] strap_sw_field;
  logic vert_expand_en, horiz_expand_en, blink_half_en, text_line_insert_en;
  logic [THR_W-1:0] dual_scan_panel_threshold;
  logic rd_q;
  logic [DATA_W-1:0] exp_q[$];
  int err_total, comparisons, cycles;
  integer seed;

  strap_and_panel_ctrl_regs u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strap_pins(strap_pins),
    .panel_on(panel_on), .panel_seq_busy(panel_seq_busy), .strap_valid(strap_valid),
    .host_bus_agp(host_bus_agp), .engine_clk_bypass(engine_clk_bypass),
    .disp_clk_bypass(disp_clk_bypass), .rom_size_64k(rom_size_64k),
    .strap_sw_field(strap_sw_field), .vert_expand_en(vert_expand_en),
    .horiz_expand_en(horiz_expand_en), .blink_half_en(blink_half_en),
    .text_line_insert_en(text_line_insert_en),
    .dual_scan_panel_threshold(dual_scan_panel_threshold)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------------------
  task automatic final_report();
    if (err_total == 0 && comparisons > 0 && exp_q.size() == 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Read data is looked at only in the one cycle where it stands; zero elsewhere.
  always @(posedge clk_sys) rd_q <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_q === 1'b1) begin
      if (exp_q.size() > 0) chk(reg_rdata, exp_q.pop_front(), "read data");
      else chk(32'h1, 32'h0, "read without note");
    end else chk(reg_rdata, DATA_ZERO, "idle read data");
  end

  // A hung run is cut short and reported as a failure.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      final_report();
    end
  end

  // ---------------------------------------------------------------------------
  // Driving
  // ---------------------------------------------------------------------------
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                     input logic [DATA_W-1:0] exp);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_addr <= a;
    reg_wdata <= wd;
    if (!w) exp_q.push_back(exp);
    @(posedge clk_sys);
  endtask : acc

  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask : idle

  task automatic do_reset(input logic [7:0] v);
    rst_n <= 1'b0;
    strap_pins <= v;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk({31'h0, strap_valid}, 32'h0, "valid in reset");
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : do_reset

  task automatic out_chk(input logic [7:0] st, input logic [7:0] cp, input logic [1:0] th);
    @(negedge clk_sys);
    chk({23'h0, strap_valid, host_bus_agp, engine_clk_bypass, disp_clk_bypass, rom_size_64k,
         strap_sw_field}, {23'h0, 1'b1, st[7], ~st[6], ~st[5], st[4], st[3:0]},
        "strap outputs");
    chk({26'h0, vert_expand_en, horiz_expand_en, blink_half_en, text_line_insert_en,
         dual_scan_panel_threshold}, {26'h0, cp[7], cp[5], cp[1], cp[0], th},
        "panel controls");
    @(posedge clk_sys);
  endtask : out_chk

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    seed = 32'hbe77fb1b;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    strap_pins = 8'hFF;
    panel_on = 1'b0;
    panel_seq_busy = 1'b0;
    err_total = 0;
    comparisons = 0;
    cycles = 0;
    @(posedge clk_sys);
    // Open pins, all pulled low, then a random board; each pass also re-tests reset values.
    for (int n = 0; n < 3; n++) begin
      s = (n == 0) ? 8'hFF : (n == 1) ? 8'h00 : 8'($random(seed));
      do_reset(s);
      acc(1'b0, OFF_STRAP, 32'h0, {24'h0, s});
      strap_pins <= ~s;
      acc(1'b1, OFF_STRAP, 32'hFFFF_FFFF, 32'h0);
      acc(1'b0, OFF_STRAP, 32'h0, {24'h0, s});
      acc(1'b0, OFF_COMP, 32'h0, {24'h0, COMP_RST});
      acc(1'b0, OFF_THR, 32'h0, 32'h0);
      idle();
      out_chk(s, COMP_RST, THR_RST);
      d = (n == 0) ? 32'hFFFF_FFFF : $random(seed);
      acc(1'b1, OFF_COMP, d, 32'h0);
      acc(1'b0, OFF_COMP, 32'h0, {24'h0, d[7:0] & COMP_MASK});
      acc(1'b1, OFF_THR, d, 32'h0);
      acc(1'b0, OFF_THR, 32'h0, {30'h0, d[1:0]});
      idle();
      out_chk(s, d[7:0] & COMP_MASK, d[1:0]);
    end
    // Status is live from the sequencer inputs; software writes do not reach it.
    for (int i = 0; i < 4; i++) begin
      panel_on <= i[0];
      panel_seq_busy <= i[1];
      acc(1'b0, OFF_STATUS, 32'h0, {30'h0, i[1], i[0]});
    end
    acc(1'b1, OFF_STATUS, 32'hFFFF_FFFF, 32'h0);
    acc(1'b0, OFF_STATUS, 32'h0, 32'h3);
    acc(1'b1, 12'h7FC, 32'hFFFF_FFFF, 32'h0);
    acc(1'b0, 12'h7FC, 32'h0, 32'h0);
    acc(1'b1, 12'h506, ~d, 32'h0);
    acc(1'b0, OFF_THR, 32'h0, {30'h0, d[1:0]});
    acc(1'b0, OFF_COMP, 32'h0, {24'h0, d[7:0] & COMP_MASK});
    idle();
    repeat (3) @(posedge clk_sys);
    final_report();
  end

endmodule : strap_and_panel_ctrl_regs_bench
